// File: hdl/rtccal_regs.v
// Purpose: register bank and timekeeping core of a serial clock
// Assumes: a byte-level serial slave on clk_sys_i feeds the ports
// Notes: oscillator pin is sampled by clk_sys_i, not used as a clock
//
// Behaviour
// RQ1 - eight-bit pointer, no answer above 0FH
// RQ2 - disabled alarm fields are ignored
// RQ3 - alarm irq enable read/write, resets zero
// RQ4 - alarm flag: write 0 clears, 1 keeps
// RQ5 - square pin floats unless enabled, enable resets 1
// RQ6 - two-bit select picks one of four rates
// RQ7 - seconds BCD 00-59, carry into minutes
// RQ8 - minutes BCD 00-59, carry into hours
// RQ9 - hours 00-23, carry into date and weekday
// RQ10 - oscillator stop flag in seconds bit7, resets 1
// RQ11 - weekday counts 00 to 06 then 00
// RQ12 - date ends at 31 or 30 per month
// RQ13 - February ends at 29 leap, else 28
// RQ14 - date wrap increments month
// RQ15 - month 1-12, wrap increments year
// RQ16 - year 00-99, multiples of four are leap
// RQ17 - all time fields held in BCD
// RQ18 - unused bits have no storage
// RQ19 - alarm flag sets on a new match only
// RQ20 - enabled alarm drives low-active interrupt
// RQ21 - pointer auto-increments after each byte
// RQ22 - seconds and the three divided square rates from one divider, 32K rate from the oscillator
// RQ23 - writes load counters, counting continues
`timescale 1ns/10ps
`include "rtccal_defs.vh"

module rtccal_regs #(
  parameter OSC_LOSS_CYC = `RTC_OSC_LOSS_US * `RTC_SYS_MHZ,
  parameter LOSS_W = 24
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire osc_clk_i,
  input wire addr_load_i,
  input wire [7:0] addr_byte_i,
  input wire wr_stb_i,
  input wire [7:0] wr_data_i,
  input wire rd_stb_i,
  output wire reg_ack_o,
  output wire [7:0] rd_data_o,
  output wire rd_valid_o,
  output wire [7:0] reg_ptr_o,
  output wire alarm_irq_n_o,
  output wire square_wave_pin_o,
  output wire square_wave_pin_oe_o
);

  localparam [31:0] LOSS_FULL = OSC_LOSS_CYC - 1;
  localparam [LOSS_W-1:0] LOSS_LAST = LOSS_FULL[LOSS_W-1:0];
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] >= `RTC_BCD_NINE) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction
  function in_range;
    input [7:0] a;
    begin
      in_range = (a <= `RTC_A_LAST);
    end
  endfunction
  function is_leap;
    input [7:0] y;
    reg [1:0] s;
    begin
      s = {y[4], 1'b0} + y[1:0];
      is_leap = (s == 2'h0);
    end
  endfunction
  function [5:0] month_len;
    input [4:0] m;
    input [7:0] y;
    begin
      if (m == `RTC_MON_FEB) begin
        month_len = is_leap(y) ? `RTC_LEN_29 : `RTC_LEN_28;
      end else if (m == `RTC_MON_APR || m == `RTC_MON_JUN ||
                   m == `RTC_MON_SEP || m == `RTC_MON_NOV) begin
        month_len = `RTC_LEN_30;
      end else begin
        month_len = `RTC_LEN_31;
      end
    end
  endfunction
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg osc_s1_r, osc_s2_r, osc_s3_r;
  reg [`RTC_DIV_W-1:0] div_r;
  reg [LOSS_W-1:0] loss_cnt_r;
  reg [7:0] ptr_r;
  reg [7:0] rd_data_r;
  reg rd_valid_r;
  reg osf_r, af_r, aie_r, square_out_enable_r;
  reg [1:0] rs_r;
  reg [6:0] sec_r, min_r;
  reg [5:0] hour_r, date_r;
  reg [2:0] wday_r;
  reg [4:0] mon_r;
  reg [7:0] year_r;
  reg [7:0] amin_r;
  reg [6:0] ahour_r, adate_r;
  reg [3:0] awday_r;
  reg match_prev_r;
  reg sqw_r;
  reg irq_n_r;
  reg [7:0] rd_mux;
  reg sqw_nxt;
  // ----------------------------------------------------------------
  // oscillator sampling and divider
  // ----------------------------------------------------------------
  wire osc_rise = osc_s2_r & ~osc_s3_r;
  wire sec_tick = osc_rise & (&div_r); // RQ22
  wire osc_dead = (loss_cnt_r == LOSS_LAST);
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_clk_i;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire ptr_ok = in_range(ptr_r);
  wire wr_en = wr_stb_i & ptr_ok; // RQ1
  wire w_ctrl2 = wr_en && (ptr_r == `RTC_A_CTRL2);
  wire w_sec = wr_en && (ptr_r == `RTC_A_SEC);
  wire w_min = wr_en && (ptr_r == `RTC_A_MIN);
  wire w_hour = wr_en && (ptr_r == `RTC_A_HOUR);
  wire w_date = wr_en && (ptr_r == `RTC_A_DATE);
  wire w_wday = wr_en && (ptr_r == `RTC_A_WDAY);
  wire w_mon = wr_en && (ptr_r == `RTC_A_MON);
  wire w_year = wr_en && (ptr_r == `RTC_A_YEAR);
  wire w_amin = wr_en && (ptr_r == `RTC_A_AMIN);
  wire w_ahour = wr_en && (ptr_r == `RTC_A_AHOUR);
  wire w_adate = wr_en && (ptr_r == `RTC_A_ADATE);
  wire w_awday = wr_en && (ptr_r == `RTC_A_AWDAY);
  wire w_sqw = wr_en && (ptr_r == `RTC_A_SQW);
  // address byte is answered by its own value, data by the pointer
  assign reg_ack_o = addr_load_i ? in_range(addr_byte_i) : ptr_ok; // RQ1
  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign reg_ptr_o = ptr_r;
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ptr_r <= `RTC_A_CTRL1;
    end else if (addr_load_i) begin
      ptr_r <= addr_byte_i;
    end else if (wr_stb_i || rd_stb_i) begin
      ptr_r <= ptr_r + 8'h01; // RQ21
    end
  end
  // unused bits read as zero, no storage behind them
  always @* begin
    rd_mux = 8'h00;
    if (ptr_r == `RTC_A_CTRL2) begin
      rd_mux[`RTC_B_AF] = af_r;
      rd_mux[`RTC_B_AIE] = aie_r; // RQ3
    end else if (ptr_r == `RTC_A_SEC) begin
      rd_mux = {osf_r, sec_r}; // RQ10
    end else if (ptr_r == `RTC_A_MIN) begin
      rd_mux = {1'b0, min_r};
    end else if (ptr_r == `RTC_A_HOUR) begin
      rd_mux = {2'h0, hour_r};
    end else if (ptr_r == `RTC_A_DATE) begin
      rd_mux = {2'h0, date_r};
    end else if (ptr_r == `RTC_A_WDAY) begin
      rd_mux = {5'h00, wday_r};
    end else if (ptr_r == `RTC_A_MON) begin
      rd_mux = {3'h0, mon_r};
    end else if (ptr_r == `RTC_A_YEAR) begin
      rd_mux = year_r;
    end else if (ptr_r == `RTC_A_AMIN) begin
      rd_mux = amin_r;
    end else if (ptr_r == `RTC_A_AHOUR) begin
      rd_mux = {ahour_r[6], 1'b0, ahour_r[5:0]}; // RQ18
    end else if (ptr_r == `RTC_A_ADATE) begin
      rd_mux = {adate_r[6], 1'b0, adate_r[5:0]}; // RQ18
    end else if (ptr_r == `RTC_A_AWDAY) begin
      rd_mux = {awday_r[3], 4'h0, awday_r[2:0]}; // RQ18
    end else if (ptr_r == `RTC_A_SQW) begin
      rd_mux = {square_out_enable_r, 5'h00, rs_r};
    end
  end
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_stb_i & ptr_ok; // RQ1
      if (rd_stb_i && ptr_ok) begin
        rd_data_r <= rd_mux;
      end
    end
  end
  // ----------------------------------------------------------------
  // time counter chain
  // ----------------------------------------------------------------
  wire [5:0] mlen = month_len(mon_r, year_r);
  wire sec_wrap = sec_tick && (sec_r >= `RTC_SEC_MAX); // RQ7
  wire min_wrap = sec_wrap && (min_r >= `RTC_MIN_MAX); // RQ8
  wire hour_wrap = min_wrap && (hour_r >= `RTC_HOUR_MAX); // RQ9
  wire date_wrap = hour_wrap && (date_r >= mlen); // RQ12 RQ13
  wire mon_wrap = date_wrap && (mon_r >= `RTC_MON_MAX); // RQ15
  wire [7:0] sec_inc = bcd_inc({1'b0, sec_r}); // RQ17
  wire [7:0] min_inc = bcd_inc({1'b0, min_r});
  wire [7:0] hour_inc = bcd_inc({2'h0, hour_r});
  wire [7:0] date_inc = bcd_inc({2'h0, date_r});
  wire [7:0] mon_inc = bcd_inc({3'h0, mon_r});
  wire [7:0] year_inc = bcd_inc(year_r);
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      div_r <= {`RTC_DIV_W{1'b0}};
    end else if (w_sec) begin
      div_r <= {`RTC_DIV_W{1'b0}}; // RQ23
    end else if (osc_rise) begin
      div_r <= div_r + {{(`RTC_DIV_W-1){1'b0}}, 1'b1}; // RQ22
    end
  end
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sec_r <= `RTC_RST_ZERO7;
      min_r <= `RTC_RST_ZERO7;
      hour_r <= `RTC_RST_ZERO6;
      date_r <= `RTC_RST_DATE;
      wday_r <= `RTC_RST_ZERO3;
      mon_r <= `RTC_RST_MON;
      year_r <= `RTC_RST_ZERO8;
    end else begin
      if (w_sec) begin
        sec_r <= wr_data_i[6:0]; // RQ23
      end else if (sec_wrap) begin
        sec_r <= `RTC_RST_ZERO7; // RQ7
      end else if (sec_tick) begin
        sec_r <= sec_inc[6:0];
      end
      if (w_min) begin
        min_r <= wr_data_i[6:0]; // RQ23
      end else if (min_wrap) begin
        min_r <= `RTC_RST_ZERO7;
      end else if (sec_wrap) begin
        min_r <= min_inc[6:0]; // RQ7
      end
      if (w_hour) begin
        hour_r <= wr_data_i[5:0]; // RQ23
      end else if (hour_wrap) begin
        hour_r <= `RTC_RST_ZERO6;
      end else if (min_wrap) begin
        hour_r <= hour_inc[5:0]; // RQ8
      end
      if (w_date) begin
        date_r <= wr_data_i[5:0]; // RQ23
      end else if (date_wrap) begin
        date_r <= `RTC_RST_DATE; // RQ12
      end else if (hour_wrap) begin
        date_r <= date_inc[5:0]; // RQ9
      end
      if (w_wday) begin
        wday_r <= wr_data_i[2:0]; // RQ23
      end else if (hour_wrap) begin
        if (wday_r >= `RTC_WDAY_MAX) begin
          wday_r <= `RTC_RST_ZERO3; // RQ11
        end else begin
          wday_r <= wday_r + 3'h1; // RQ9
        end
      end
      if (w_mon) begin
        mon_r <= wr_data_i[4:0]; // RQ23
      end else if (mon_wrap) begin
        mon_r <= `RTC_RST_MON; // RQ15
      end else if (date_wrap) begin
        mon_r <= mon_inc[4:0]; // RQ14
      end
      if (w_year) begin
        year_r <= wr_data_i; // RQ23
      end else if (mon_wrap) begin
        if (year_r >= `RTC_YEAR_MAX) begin
          year_r <= `RTC_RST_ZERO8; // RQ16
        end else begin
          year_r <= year_inc; // RQ15
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // oscillator stop detection
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      loss_cnt_r <= {LOSS_W{1'b0}};
      osf_r <= `RTC_RST_OSF;
    end else begin
      if (osc_rise) begin
        loss_cnt_r <= {LOSS_W{1'b0}};
      end else if (!osc_dead) begin
        loss_cnt_r <= loss_cnt_r + {{(LOSS_W-1){1'b0}}, 1'b1};
      end
      // a detected stop wins over a clearing write
      if (osc_dead) begin
        osf_r <= 1'b1; // RQ10
      end else if (w_sec) begin
        osf_r <= wr_data_i[`RTC_B_OSF];
      end
    end
  end
  // ----------------------------------------------------------------
  // alarm
  // ----------------------------------------------------------------
  wire m_min = amin_r[`RTC_B_AE] | (amin_r[6:0] == min_r); // RQ2
  wire m_hour = ahour_r[6] | (ahour_r[5:0] == hour_r); // RQ2
  wire m_date = adate_r[6] | (adate_r[5:0] == date_r); // RQ2
  wire m_wday = awday_r[3] | (awday_r[2:0] == wday_r); // RQ2
  wire match = m_min & m_hour & m_date & m_wday;
  wire new_match = match & ~match_prev_r; // RQ19
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      amin_r <= 8'h00;
      ahour_r <= 7'h00;
      adate_r <= 7'h00;
      awday_r <= 4'h0;
      aie_r <= `RTC_RST_AIE;
      af_r <= `RTC_RST_AF;
      match_prev_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else begin
      if (w_amin) begin
        amin_r <= wr_data_i;
      end
      if (w_ahour) begin
        ahour_r <= {wr_data_i[`RTC_B_AE], wr_data_i[5:0]}; // RQ18
      end
      if (w_adate) begin
        adate_r <= {wr_data_i[`RTC_B_AE], wr_data_i[5:0]}; // RQ18
      end
      if (w_awday) begin
        awday_r <= {wr_data_i[`RTC_B_AE], wr_data_i[2:0]}; // RQ18
      end
      if (w_ctrl2) begin
        aie_r <= wr_data_i[`RTC_B_AIE]; // RQ3
      end
      match_prev_r <= match;
      if (new_match) begin
        af_r <= 1'b1; // RQ19
      end else if (w_ctrl2 && !wr_data_i[`RTC_B_AF]) begin
        af_r <= 1'b0; // RQ4
      end
      irq_n_r <= ~(af_r & aie_r); // RQ20
    end
  end
  assign alarm_irq_n_o = irq_n_r;
  // ----------------------------------------------------------------
  // square wave output
  // ----------------------------------------------------------------
  always @* begin
    sqw_nxt = osc_s2_r;
    case (rs_r)
      `RTC_RS_32K: sqw_nxt = osc_s2_r;
      `RTC_RS_1K: sqw_nxt = div_r[`RTC_TAP_1K];
      `RTC_RS_32: sqw_nxt = div_r[`RTC_TAP_32];
      `RTC_RS_1: sqw_nxt = div_r[`RTC_TAP_1];
      default: sqw_nxt = osc_s2_r;
    endcase
  end
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      square_out_enable_r <= `RTC_RST_SQUARE_OUT_ENABLE;
      rs_r <= `RTC_RST_RS;
      sqw_r <= 1'b0;
    end else begin
      if (w_sqw) begin
        square_out_enable_r <= wr_data_i[`RTC_B_SQUARE_OUT_ENABLE]; // RQ5
        rs_r <= wr_data_i[1:0]; // RQ6
      end
      sqw_r <= sqw_nxt; // RQ6 RQ22
    end
  end
  assign square_wave_pin_o = sqw_r;
  assign square_wave_pin_oe_o = square_out_enable_r; // RQ5
endmodule // rtccal_regs

// File: hdl/rtccal_defs.vh
// Purpose: shared constants of the clock/calendar register block
// Assumes: registers are eight bits wide, time fields are BCD
// Notes: included by bare name
`ifndef RTCCAL_DEFS_VH
`define RTCCAL_DEFS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define RTC_A_CTRL1 8'h00
`define RTC_A_CTRL2 8'h01
`define RTC_A_SEC 8'h02
`define RTC_A_MIN 8'h03
`define RTC_A_HOUR 8'h04
`define RTC_A_DATE 8'h05
`define RTC_A_WDAY 8'h06
`define RTC_A_MON 8'h07
`define RTC_A_YEAR 8'h08
`define RTC_A_AMIN 8'h09
`define RTC_A_AHOUR 8'h0A
`define RTC_A_ADATE 8'h0B
`define RTC_A_AWDAY 8'h0C
`define RTC_A_SQW 8'h0D
`define RTC_A_LAST 8'h0F

// ----------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------
`define RTC_B_AF 3
`define RTC_B_AIE 1
`define RTC_B_OSF 7
`define RTC_B_AE 7
`define RTC_B_SQUARE_OUT_ENABLE 7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RTC_RST_OSF 1'b1
`define RTC_RST_AF 1'b0
`define RTC_RST_AIE 1'b0
`define RTC_RST_SQUARE_OUT_ENABLE 1'b1
`define RTC_RST_RS 2'h0
`define RTC_RST_ZERO7 7'h00
`define RTC_RST_ZERO6 6'h00
`define RTC_RST_ZERO3 3'h0
`define RTC_RST_ZERO8 8'h00
`define RTC_RST_DATE 6'h01
`define RTC_RST_MON 5'h01

// ----------------------------------------------------------------
// square wave rate codes and divider taps
// ----------------------------------------------------------------
`define RTC_RS_32K 2'h0
`define RTC_RS_1K 2'h1
`define RTC_RS_32 2'h2
`define RTC_RS_1 2'h3
`define RTC_DIV_W 15
`define RTC_TAP_1K 4
`define RTC_TAP_32 9
`define RTC_TAP_1 14

// ----------------------------------------------------------------
// BCD limits
// ----------------------------------------------------------------
`define RTC_SEC_MAX 7'h59
`define RTC_MIN_MAX 7'h59
`define RTC_HOUR_MAX 6'h23
`define RTC_WDAY_MAX 3'h6
`define RTC_MON_MAX 5'h12
`define RTC_YEAR_MAX 8'h99
`define RTC_MON_FEB 5'h02
`define RTC_MON_APR 5'h04
`define RTC_MON_JUN 5'h06
`define RTC_MON_SEP 5'h09
`define RTC_MON_NOV 5'h11
`define RTC_LEN_31 6'h31
`define RTC_LEN_30 6'h30
`define RTC_LEN_29 6'h29
`define RTC_LEN_28 6'h28
`define RTC_BCD_NINE 4'h9

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTC_SYS_MHZ 100
`define RTC_OSC_LOSS_US 1000

`endif

// File: dv/rtccal_regs_checker.sv
// Purpose: port assertions for the clock register block
// Assumes: one clock, synchronous active-low reset
// Notes: bound onto rtccal_regs
`timescale 1ns/10ps
module rtccal_regs_checker (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire osc_clk_i,
  input wire addr_load_i,
  input wire [7:0] addr_byte_i,
  input wire wr_stb_i,
  input wire [7:0] wr_data_i,
  input wire rd_stb_i,
  input wire reg_ack_o,
  input wire [7:0] rd_data_o,
  input wire rd_valid_o,
  input wire [7:0] reg_ptr_o,
  input wire alarm_irq_n_o,
  input wire square_wave_pin_o,
  input wire square_wave_pin_oe_o
);
  // ------
  // storage bits per address
  // ------
  function automatic [7:0] live_bits(input [7:0] a);
    case (a)
      8'h01: live_bits = 8'h0A;
      8'h02, 8'h08, 8'h09: live_bits = 8'hFF;
      8'h03: live_bits = 8'h7F;
      8'h04, 8'h05: live_bits = 8'h3F;
      8'h06: live_bits = 8'h07;
      8'h07: live_bits = 8'h1F;
      8'h0A, 8'h0B: live_bits = 8'hBF;
      8'h0C: live_bits = 8'h87;
      8'h0D: live_bits = 8'h83;
      default: live_bits = 8'h00;
    endcase
  endfunction
  wire bus_op = (wr_stb_i || rd_stb_i) && !addr_load_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ------
  // properties
  // ------
  chk_addr_answer: assert property (
    addr_load_i |-> reg_ack_o == (addr_byte_i <= 8'h0F))
    else $error("address byte answer wrong");
  chk_byte_answer: assert property (
    bus_op |-> reg_ack_o == (reg_ptr_o <= 8'h0F))
    else $error("data byte answer wrong");
  chk_read_valid: assert property (
    rd_stb_i && !addr_load_i |=> rd_valid_o == ($past(reg_ptr_o) <= 8'h0F))
    else $error("read valid wrong");
  chk_ptr_load: assert property (
    addr_load_i |=> reg_ptr_o == $past(addr_byte_i))
    else $error("pointer not loaded");
  chk_ptr_step: assert property (
    bus_op |=> reg_ptr_o == $past(reg_ptr_o) + 8'h01)
    else $error("pointer did not step");
  chk_unused_zero: assert property (
    rd_valid_o |-> (rd_data_o & ~live_bits($past(reg_ptr_o))) == 8'h00)
    else $error("unused bit read as one");
  chk_irq_level: assert property (
    rd_valid_o && $past(reg_ptr_o) == 8'h01
    |-> alarm_irq_n_o == !(rd_data_o[3] && rd_data_o[1]))
    else $error("interrupt level disagrees with flag");
  chk_oe_follow: assert property (
    wr_stb_i && !addr_load_i && reg_ptr_o == 8'h0D
    |-> ##2 square_wave_pin_oe_o == $past(wr_data_i[7], 2))
    else $error("square enable not followed");
  chk_reset_state: assert property (
    $rose(rst_b_i) |-> alarm_irq_n_o && square_wave_pin_oe_o
    && reg_ptr_o == 8'h00)
    else $error("reset state wrong");
  cover property (rd_valid_o);
  cover property (!alarm_irq_n_o);
  cover property (addr_load_i && !reg_ack_o);
endmodule // rtccal_regs_checker

bind rtccal_regs rtccal_regs_checker u_chk (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .osc_clk_i(osc_clk_i),
  .addr_load_i(addr_load_i), .addr_byte_i(addr_byte_i),
  .wr_stb_i(wr_stb_i), .wr_data_i(wr_data_i), .rd_stb_i(rd_stb_i),
  .reg_ack_o(reg_ack_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .reg_ptr_o(reg_ptr_o), .alarm_irq_n_o(alarm_irq_n_o),
  .square_wave_pin_o(square_wave_pin_o),
  .square_wave_pin_oe_o(square_wave_pin_oe_o)
);

// File: dv/rtccal_host_model.sv
// Purpose: host side of the byte port, one byte per strobe
// Assumes: requests launched just after a rising clock edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/10ps
module rtccal_host_model (
  input wire clk_sys_i,
  input wire rd_valid_i,
  input wire [7:0] rd_data_i,
  output logic addr_load_o,
  output logic [7:0] addr_byte_o,
  output logic wr_stb_o,
  output logic [7:0] wr_data_o,
  output logic rd_stb_o
);
  initial begin
    addr_load_o = 1'b0;
    addr_byte_o = 8'h00;
    wr_stb_o = 1'b0;
    wr_data_o = 8'h00;
    rd_stb_o = 1'b0;
  end
  // one byte slot: kind 1 loads the address, 2 writes, 3 reads
  task automatic slot(input logic [1:0] kind, input logic [7:0] b);
    @(posedge clk_sys_i);
    addr_load_o <= (kind == 2'h1);
    wr_stb_o <= (kind == 2'h2);
    rd_stb_o <= (kind == 2'h3);
    if (kind == 2'h1) addr_byte_o <= b;
    if (kind == 2'h2) wr_data_o <= b;
    @(posedge clk_sys_i);
    addr_load_o <= 1'b0;
    wr_stb_o <= 1'b0;
    rd_stb_o <= 1'b0;
    if (kind == 2'h1) addr_byte_o <= ~b;
    if (kind == 2'h2) wr_data_o <= ~b;
  endtask
  task automatic put_addr(input logic [7:0] a);
    slot(2'h1, a);
  endtask
  task automatic put_byte(input logic [7:0] d);
    slot(2'h2, d);
  endtask
  task automatic get_byte(output logic [7:0] d, output logic ok);
    slot(2'h3, 8'h00);
    #1;
    ok = rd_valid_i;
    d = rd_data_i;
  endtask
endmodule // rtccal_host_model

// File: dv/rtc_calendar_alarm_regs_test.sv
// Purpose: self-checking bench of the clock register block
// Assumes: oscillator period 160 ns, loss limit shortened
// Notes: seconds never tick within the run length
`timescale 1ns/10ps
module rtc_calendar_alarm_regs_test;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic osc_clk_i = 1'b0;
  logic osc_run = 1'b1;
  wire al, wr, rd, ack, rv, irq_n, square_wave_pin, sqw_oe;
  wire [7:0] ab, wd, rdat, ptr;
  int num_errors = 0;
  int total_checks = 0;
  int i;
  int r;
  logic ok;
  logic [7:0] d;
  logic [7:0] s;
  logic [15:0] n;
  logic [7:0] v [0:5];
  always #5 clk_sys_i = ~clk_sys_i;
  always #80 if (osc_run) osc_clk_i = ~osc_clk_i;
  rtccal_host_model host (.clk_sys_i(clk_sys_i), .rd_valid_i(rv),
    .rd_data_i(rdat), .addr_load_o(al), .addr_byte_o(ab),
    .wr_stb_o(wr), .wr_data_o(wd), .rd_stb_o(rd));
  rtccal_regs #(.OSC_LOSS_CYC(200)) uut (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .osc_clk_i(osc_clk_i), .addr_load_i(al),
    .addr_byte_i(ab), .wr_stb_i(wr), .wr_data_i(wd), .rd_stb_i(rd),
    .reg_ack_o(ack), .rd_data_o(rdat), .rd_valid_o(rv),
    .reg_ptr_o(ptr), .alarm_irq_n_o(irq_n),
    .square_wave_pin_o(square_wave_pin), .square_wave_pin_oe_o(sqw_oe));
  // ------
  // helpers
  // ------
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h02, 8'h0D: rst_val = 8'h80;
      8'h05, 8'h07: rst_val = 8'h01;
      default: rst_val = 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] bcd(input int k);
    bcd = 8'((k / 10) * 16 + k % 10);
  endfunction
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_count(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic write_at(input logic [7:0] a, input logic [7:0] b);
    host.put_addr(a);
    host.put_byte(b);
  endtask
  task automatic read_exp(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic g;
    host.put_addr(a);
    host.get_byte(q, g);
    check_byte(q, e);
  endtask
  // half period of the square pin in clock cycles
  task automatic measure(output logic [15:0] c);
    logic lv;
    c = 16'h0000;
    repeat (3) begin
      lv = square_wave_pin;
      c = 16'h0000;
      while (square_wave_pin === lv && c < 16'd20000) begin
        tick();
        c++;
      end
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    num_errors++;
    finish_test();
  end
  // ------
  // scenarios
  // ------
  initial begin
    void'($urandom(10));
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    host.put_addr(8'h00);
    for (i = 0; i < 17; i++) begin
      host.get_byte(d, ok);
      check_byte({7'h00, ok}, {7'h00, i < 16});
      if (i < 16) check_byte(d, rst_val(i[7:0]));
    end
    repeat (4) begin
      v[0] = bcd($urandom_range(59));
      v[1] = bcd($urandom_range(23));
      v[2] = bcd($urandom_range(28, 1));
      v[3] = bcd($urandom_range(6));
      v[4] = bcd($urandom_range(12, 1));
      v[5] = bcd($urandom_range(99));
      host.put_addr(8'h03);
      for (i = 0; i < 6; i++) host.put_byte(v[i]);
      host.put_addr(8'h03);
      for (i = 0; i < 6; i++) begin
        host.get_byte(d, ok);
        check_byte(d, v[i]);
      end
    end
    host.put_addr(8'h03);
    for (i = 0; i < 4; i++) host.put_byte(i == 2 ? 8'h01 : 8'h00);
    s = bcd($urandom_range(59));
    write_at(8'h02, s);
    read_exp(8'h02, s);
    osc_run = 1'b0;
    repeat (300) @(posedge clk_sys_i);
    osc_run = 1'b1;
    read_exp(8'h02, s | 8'h80);
    read_exp(8'h01, 8'h00);
    write_at(8'h0B, 8'h80);
    read_exp(8'h01, 8'h08);
    check_byte({7'h00, irq_n}, 8'h01);
    write_at(8'h01, 8'h0A);
    read_exp(8'h01, 8'h0A);
    check_byte({7'h00, irq_n}, 8'h00);
    write_at(8'h01, 8'h02);
    read_exp(8'h01, 8'h02);
    check_byte({7'h00, irq_n}, 8'h01);
    write_at(8'h09, 8'h01);
    write_at(8'h09, 8'h00);
    read_exp(8'h01, 8'h0A);
    for (r = 0; r < 3; r++) begin
      write_at(8'h0D, {6'h20, r[1:0]});
      read_exp(8'h0D, {6'h20, r[1:0]});
      measure(n);
      check_count(n, 16'd8 << (5 * r));
    end
    write_at(8'h0D, 8'h83);
    write_at(8'h02, 8'h00);
    repeat (10) tick();
    check_byte({7'h00, square_wave_pin}, 8'h00);
    repeat (2000) tick();
    check_byte({7'h00, square_wave_pin}, 8'h00);
    write_at(8'h0D, 8'h03);
    repeat (3) tick();
    check_byte({7'h00, sqw_oe}, 8'h00);
    host.put_addr(8'h10 + 8'($urandom_range(239)));
    host.put_byte(8'hFF);
    host.put_addr(8'hFF);
    host.get_byte(d, ok);
    check_byte({7'h00, ok}, 8'h00);
    host.get_byte(d, ok);
    check_byte({7'h00, ok}, 8'h01);
    check_byte(d, 8'h00);
    finish_test();
  end
endmodule // rtc_calendar_alarm_regs_test
